// [hdl/dfa_regs.svh]
// Purpose: Field positions, codes and reset values of the synthesizer core
// Assumes: 24-bit serial control words, 2-bit address in the top bits
// Notes: Definitions only
`ifndef DFA_REGS_SVH
`define DFA_REGS_SVH

// Serial word layout
`define DFA_ADDR_MSB 23
`define DFA_ADDR_LSB 22
`define DFA_DATA_MSB 21
`define DFA_DATA_LSB 0

// Mode1 configuration word fields
`define DFA_MM_BIT 16
`define DFA_DIV_BIT 17
`define DFA_GAIN_MSB 20
`define DFA_GAIN_LSB 18

// Fields shared by both mode configuration words
`define DFA_VCO_BIT 11
`define DFA_PLL_BIT 12

// Mode0 configuration word carries the deviation byte
`define DFA_DEV_MSB 20
`define DFA_DEV_LSB 13

// Padding used when placing words into the frequency register
`define DFA_FW_PAD 2'h0
`define DFA_DEV_PAD 2'h0
`define DFA_DEV_TOP 14'h0000

// Reset values
`define DFA_RST_WORD 22'h000000
`define DFA_RST_DEV 8'h00
`define DFA_RST_ACC 24'h000000
`define DFA_RST_SHIFT 24'h000000
`define DFA_RST_GAIN 3'h0

// Accumulator bits that index the sine table
`define DFA_ROM_IDX_MSB 23
`define DFA_ROM_IDX_LSB 16

// Synchronised input positions
`define DFA_IN_SCLK 0
`define DFA_IN_SDAT 1
`define DFA_IN_STB 2
`define DFA_IN_MODE 3
`define DFA_IN_TXD 4
`define DFA_IN_LOCK 5
`define DFA_IN_N 6

`endif

// [hdl/dfa_pkg.sv]
// Purpose: Types of the synthesizer core
// Assumes: Widths fixed by the accumulator and word formats
// Notes: Constants live in dfa_regs.svh
package dfa_pkg;
    localparam int ACC_W = 24;
    localparam int FW_W = 22;
    localparam int DEV_W = 8;
    localparam int DAC_W = 11;
    localparam int GAIN_W = 3;

    typedef logic [ACC_W-1:0] dfa_acc_t;
    typedef logic [FW_W-1:0] dfa_fw_t;
    typedef logic [DEV_W-1:0] dfa_dev_t;
    typedef logic [DAC_W-1:0] dfa_dac_t;
    typedef logic [GAIN_W-1:0] dfa_gain_t;

    // Latch selected by the address bits of a serial word
    typedef enum logic [1:0] {
        DFA_ADDR_P0 = 2'b00,
        DFA_ADDR_P1 = 2'b01,
        DFA_ADDR_CFG1 = 2'b10,
        DFA_ADDR_CFG0 = 2'b11
    } dfa_addr_t;
endpackage

// [hdl/dfa_sine_rom.sv]
// Purpose: Phase to amplitude table for the DAC
// Assumes: Parabolic half-wave shape is close enough to a sine
// Notes: Read data come out of a register, one cycle after the index
`timescale 1ns/1ps
module dfa_sine_rom #(
    parameter int IDX_W = 8,
    parameter int DAT_W = 11
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [IDX_W-1:0] idx,
    output logic [DAT_W-1:0] data_q
);
    localparam int X_W = IDX_W - 1;
    localparam logic [X_W-1:0] X_MAX = {X_W{1'b1}};
    localparam logic [DAT_W-1:0] MID = {1'b1, {(DAT_W-1){1'b0}}};

    ////////////////////////////////////////////////////////////////////
    // Amplitude: x*(max-x) gives a smooth hump per half period
    wire logic [X_W-1:0] x = idx[X_W-1:0];
    wire logic [2*X_W-1:0] prod = x * (X_MAX - x);
    wire logic [DAT_W-1:0] mag = {1'b0, prod[DAT_W:2]};
    wire logic [DAT_W-1:0] data_d = idx[IDX_W-1] ? (MID - mag) : (MID + mag);

    ////////////////////////////////////////////////////////////////////
    // Registered read port
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            data_q <= {DAT_W{1'b0}};
        end else if (clk_en) begin
            data_q <= data_d;
        end
    end
endmodule // dfa_sine_rom

// [hdl/dfa_top.sv]
// Purpose: Phase accumulator, frequency selection and serial word latches
// Assumes: Serial pins, mode, data and lock inputs are asynchronous
// Notes: Only rstn clears the latches; clk_en low freezes everything
//
// Functional notes
// R1: Accumulator of 24 bits advances by the frequency register every clock.
// R2: Frequency words are 22 bits; top two register bits forced to zero.
// R3: Mode pin picks profile0 or profile1 frequency word.
// R4: Deviation byte sits two bits up, weighted by four.
// R5: Transmit data high adds four times deviation; low uses word alone.
// R6: Deviation only applies while modulation select bit 16 is zero.
// R7: Words and deviation persist through standby; no reload needed.
// R8: Configuration field chooses PLL divide ratio 256 or 512.
// R9: Acquisition pump pulses only while unlocked, silent once locked.
// R10: Three-bit field sets acquisition current gain.
// R11: Host clears oscillator enable bit when external oscillator used.
// R12: Host should pick the smallest divide ratio the application allows.
// R13: Words shifted MSB first, data sampled on serial clock rising edge.
// R14: Strobe high moves shift register into addressed latch; lines low.
// R15: Accumulator wraps modulo 2^24; upper bits index sine table.
// R16: Mode and transmit data are synchronised before use.
`timescale 1ns/1ps
`include "dfa_regs.svh"
module dfa_top (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_strobe,
    input wire logic mode_sel,
    input wire logic tx_data,
    input wire logic pll_locked,
    output dfa_pkg::dfa_dac_t dac_code,
    output logic acquisition_pump_out,
    output dfa_pkg::dfa_gain_t acquisition_gain,
    output logic divide_512,
    output logic oscillator_enable,
    output logic pll_enable
);
    import dfa_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers, one per asynchronous input
    wire logic [`DFA_IN_N-1:0] raw_in = {pll_locked, tx_data, mode_sel,
                                         ser_strobe, ser_data, ser_clk};
    logic [`DFA_IN_N-1:0] meta_q;
    logic [`DFA_IN_N-1:0] sync_q;
    genvar gi;
    generate
        for (gi = 0; gi < `DFA_IN_N; gi++) begin : g_sync
            // First flop is read only by the second
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else if (clk_en) begin
                    meta_q[gi] <= raw_in[gi]; // [R16]
                    sync_q[gi] <= meta_q[gi]; // [R16]
                end
            end
        end
    endgenerate

    wire logic sclk_s = sync_q[`DFA_IN_SCLK];
    wire logic sdat_s = sync_q[`DFA_IN_SDAT];
    wire logic stb_s = sync_q[`DFA_IN_STB];
    wire logic mode_s = sync_q[`DFA_IN_MODE];
    wire logic txd_s = sync_q[`DFA_IN_TXD];
    wire logic lock_s = sync_q[`DFA_IN_LOCK];

    ////////////////////////////////////////////////////////////////////
    // Edge finding on the synchronised serial clock and strobe
    logic sclk_d1_q;
    logic stb_d1_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sclk_d1_q <= 1'b0;
            stb_d1_q <= 1'b0;
        end else if (clk_en) begin
            sclk_d1_q <= sclk_s;
            stb_d1_q <= stb_s;
        end
    end
    wire logic sclk_rise = sclk_s & ~sclk_d1_q;
    wire logic stb_rise = stb_s & ~stb_d1_q;

    ////////////////////////////////////////////////////////////////////
    // Serial shift register; older leading bits fall off the top
    dfa_acc_t shift_q;
    wire dfa_acc_t shift_d = sclk_rise ? {shift_q[ACC_W-2:0], sdat_s} : shift_q; // [R13]
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shift_q <= `DFA_RST_SHIFT;
        end else if (clk_en) begin
            shift_q <= shift_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address decode of the strobed word
    wire dfa_addr_t addr = dfa_addr_t'(shift_q[`DFA_ADDR_MSB:`DFA_ADDR_LSB]);
    wire dfa_fw_t word = shift_q[`DFA_DATA_MSB:`DFA_DATA_LSB];
    wire logic ld_p0 = stb_rise & (addr == DFA_ADDR_P0); // [R14]
    wire logic ld_p1 = stb_rise & (addr == DFA_ADDR_P1); // [R14]
    wire logic ld_c1 = stb_rise & (addr == DFA_ADDR_CFG1); // [R14]
    wire logic ld_c0 = stb_rise & (addr == DFA_ADDR_CFG0); // [R14]

    ////////////////////////////////////////////////////////////////////
    // Static latches; only power-up reset clears them, so standby keeps them
    dfa_fw_t p0_q;
    dfa_fw_t p1_q;
    dfa_fw_t cfg1_q;
    dfa_fw_t cfg0_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            p0_q <= `DFA_RST_WORD;
            p1_q <= `DFA_RST_WORD;
            cfg1_q <= `DFA_RST_WORD;
            cfg0_q <= `DFA_RST_WORD;
        end else if (clk_en) begin
            if (ld_p0) p0_q <= word; // [R7]
            if (ld_p1) p1_q <= word; // [R7]
            if (ld_c1) cfg1_q <= word; // [R7]
            if (ld_c0) cfg0_q <= word; // [R7]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Frequency register: selected word plus optional deviation
    wire dfa_dev_t dev = cfg0_q[`DFA_DEV_MSB:`DFA_DEV_LSB];
    wire logic mm = cfg1_q[`DFA_MM_BIT];
    wire dfa_fw_t sel_word = mode_s ? p1_q : p0_q; // [R3]
    wire logic dev_on = ~mm & txd_s; // [R5] [R6]
    wire dfa_acc_t base_term = {`DFA_FW_PAD, sel_word}; // [R2]
    wire dfa_acc_t dev_term = {`DFA_DEV_TOP, dev, `DFA_DEV_PAD}; // [R4]
    wire dfa_acc_t freq_d = dev_on ? base_term + dev_term : base_term; // [R5]
    dfa_acc_t freq_q;
    dfa_acc_t acc_q;
    // Carry out of the top bit is dropped, giving the modulo wrap
    wire dfa_acc_t acc_d = acc_q + freq_q; // [R1] [R15]
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            freq_q <= `DFA_RST_ACC;
            acc_q <= `DFA_RST_ACC;
        end else if (clk_en) begin
            freq_q <= freq_d;
            acc_q <= acc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sine lookup; registered output feeds the DAC directly
    dfa_sine_rom #(
        .IDX_W(`DFA_ROM_IDX_MSB - `DFA_ROM_IDX_LSB + 1),
        .DAT_W(DAC_W)
    ) u_rom (
        .clock(clock),
        .rstn(rstn),
        .clk_en(clk_en),
        .idx(acc_q[`DFA_ROM_IDX_MSB:`DFA_ROM_IDX_LSB]), // [R15]
        .data_q(dac_code)
    );

    ////////////////////////////////////////////////////////////////////
    // PLL controls; mode-specific enables follow the mode pin
    wire dfa_fw_t cfg_sel = mode_s ? cfg1_q : cfg0_q;
    // Pulses at the reference phase rate, gated by lock status
    wire logic pump_d = ~lock_s & cfg_sel[`DFA_PLL_BIT] & acc_q[ACC_W-1]; // [R9]
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            acquisition_pump_out <= 1'b0;
            acquisition_gain <= `DFA_RST_GAIN;
            divide_512 <= 1'b0;
            oscillator_enable <= 1'b0;
            pll_enable <= 1'b0;
        end else if (clk_en) begin
            acquisition_pump_out <= pump_d; // [R9]
            acquisition_gain <= cfg1_q[`DFA_GAIN_MSB:`DFA_GAIN_LSB]; // [R10]
            divide_512 <= cfg1_q[`DFA_DIV_BIT]; // [R8]
            oscillator_enable <= cfg_sel[`DFA_VCO_BIT];
            pll_enable <= cfg_sel[`DFA_PLL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_acc_step;
        clk_en |=> !clk_en || (acc_q == dfa_acc_t'($past(acc_q) + $past(freq_q)));
    endproperty
    a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong"); // [R1]

    property p_plain_word;
        (clk_en && !dev_on) |=> (freq_q == {`DFA_FW_PAD, $past(sel_word)});
    endproperty
    a_plain_word: assert property (p_plain_word) else $error("top bits not zero"); // [R2]

    property p_mode_pick;
        (clk_en && !dev_on && mode_s) |=> (freq_q[FW_W-1:0] == $past(p1_q));
    endproperty
    a_mode_pick: assert property (p_mode_pick) else $error("mode word wrong"); // [R3]

    property p_dev_add;
        (clk_en && txd_s && !mm) |=>
            (freq_q == dfa_acc_t'({`DFA_FW_PAD, $past(sel_word)} +
                                  {`DFA_DEV_TOP, $past(dev), `DFA_DEV_PAD}));
    endproperty
    a_dev_add: assert property (p_dev_add) else $error("deviation add wrong"); // [R4] [R5]

    property p_mm_block;
        (clk_en && mm) |=> (freq_q == {`DFA_FW_PAD, $past(sel_word)});
    endproperty
    a_mm_block: assert property (p_mm_block) else $error("deviation not blocked"); // [R6]

    property p_static;
        (!stb_rise || !clk_en) |=> ($stable(p0_q) && $stable(p1_q) && $stable(cfg0_q));
    endproperty
    a_static: assert property (p_static) else $error("latch changed unasked"); // [R7]

    property p_div;
        (clk_en ##1 clk_en) |-> (divide_512 == $past(cfg1_q[`DFA_DIV_BIT]));
    endproperty
    a_div: assert property (p_div) else $error("divider not following"); // [R8]

    property p_pump_off;
        (clk_en && lock_s) |=> !acquisition_pump_out;
    endproperty
    a_pump_off: assert property (p_pump_off) else $error("pump active when locked"); // [R9]

    property p_gain;
        (clk_en ##1 clk_en) |-> (acquisition_gain == $past(cfg1_q[`DFA_GAIN_MSB:`DFA_GAIN_LSB]));
    endproperty
    a_gain: assert property (p_gain) else $error("gain not following"); // [R10]

    property p_shift;
        (clk_en && sclk_rise) |=> (shift_q == {$past(shift_q[ACC_W-2:0]), $past(sdat_s)});
    endproperty
    a_shift: assert property (p_shift) else $error("shift wrong"); // [R13]

    property p_load;
        (clk_en && ld_p0) |=> (p0_q == $past(word));
    endproperty
    a_load: assert property (p_load) else $error("latch load wrong"); // [R14]
endmodule // dfa_top

// [verif/dfa_host_model.sv]
// Purpose: Host side of the three-wire programming link
// Assumes: Serial clock period of 8 system clocks, still between words
// Notes: Pins change 1 ns after a system clock edge
`timescale 1ns/1ps
module dfa_host_model (
    input wire logic clock,
    output logic ser_clk,
    output logic ser_data,
    output logic ser_strobe
);
    // Lines idle low between words
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_strobe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wait n system clocks, then step off the edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // One word MSB first; strobe only once clock and data are low
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            ser_data = w[i];
            step(4);
            ser_clk = 1'b1;
            step(4);
            ser_clk = 1'b0;
        end
        ser_data = 1'b0;
        step(4);
        ser_strobe = 1'b1;
        step(8);
        ser_strobe = 1'b0;
        step(4);
    endtask
endmodule // dfa_host_model

// [verif/dfa_top_tb_top.sv]
// Purpose: Self-checking bench of the synthesizer core
// Assumes: Pump output is seen as acc[23] while unlocked and enabled
// Notes: Step sizes are picked so the pump period is an exact count, except the fractional deviation step
`timescale 1ns/1ps
module dfa_top_tb_top;
    import dfa_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic mode_sel = 1'b0;
    logic tx_data = 1'b0;
    logic pll_locked = 1'b0;
    logic ser_clk, ser_data, ser_strobe;
    dfa_dac_t dac_code;
    dfa_gain_t acquisition_gain;
    logic acquisition_pump_out, divide_512, oscillator_enable, pll_enable;
    int n_mismatch = 0;
    int compares = 0;
    int n;

    always #10 clock = ~clock;

    dfa_host_model HOST (.clock(clock), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_strobe(ser_strobe));
    dfa_top DUT (.clock(clock), .rstn(rstn), .clk_en(clk_en), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_strobe(ser_strobe), .mode_sel(mode_sel),
        .tx_data(tx_data), .pll_locked(pll_locked), .dac_code(dac_code),
        .acquisition_pump_out(acquisition_pump_out), .acquisition_gain(acquisition_gain),
        .divide_512(divide_512), .oscillator_enable(oscillator_enable),
        .pll_enable(pll_enable));

    ////////////////////////////////////////////////////////////////////////////
    // Mode1 word: gain, divider, modulation select, pll on, oscillator off
    function automatic logic [23:0] cw(input logic [2:0] g, input logic d, input logic m);
        return {2'h2, 1'h0, g, d, m, 3'h0, 1'h1, 1'h0, 11'h000};
    endfunction

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // Cycles from one pump rise to the next, bounded
    task automatic rise(output int c);
        logic l;
        c = 0;
        do begin
            l = acquisition_pump_out;
            tick(1);
            c++;
        end while (!(l === 1'b0 && acquisition_pump_out === 1'b1) && c < 40000);
    endtask

    task automatic period(input string nm, input int e);
        rise(n);
        rise(n);
        n = (e == 16448 && n == 16449) ? 16448 : n; // Fractional step
        chk(nm, 24'(e), 24'(n));
    endtask

    // Pump must hold level v for k cycles
    task automatic quiet(input string nm, input int k, input logic v);
        logic bad;
        bad = 1'b0;
        repeat (k) begin
            tick(1);
            bad = bad | (acquisition_pump_out !== v);
        end
        chk(nm, 24'h000000, 24'(bad));
    endtask

    // Half a period apart the table mirrors about mid-scale; step must be 2^21
    task automatic dac_sym;
        logic [11:0] a;
        logic moved;
        a = 12'(dac_code);
        moved = 1'b0;
        repeat (4) begin
            tick(1);
            moved = moved | (dac_code !== a[10:0]);
        end
        chk("dac_sym", 24'(1 << DAC_W), 24'(a + 12'(dac_code)));
        chk("dac_moves", 24'h000001, 24'(moved));
    endtask

    task automatic complete_run;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Longest path is two slow deviation periods plus one quiet span
    initial begin
        // Tests need about 48k cycles; limit sits well above that at 80k cycles
        #1600000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        tick(4);
        rstn = 1'b1;
        chk("gain_reset", 24'h000000, 24'(acquisition_gain));
        HOST.send(cw(3'h5, 1'b1, 1'b0));
        HOST.send({2'h3, 1'h0, 8'hFF, 1'h1, 1'h1, 11'h000});
        HOST.send({2'h0, 22'h100000});
        HOST.send({2'h1, 22'h200000});
        mode_sel = 1'b1;
        tick(8);
        chk("gain", 24'h000005, 24'(acquisition_gain));
        chk("div512", 24'h000001, 24'(divide_512));
        chk("osc_en1", 24'h000000, 24'(oscillator_enable));
        chk("pll_en1", 24'h000001, 24'(pll_enable));
        period("period_p1", 8);
        dac_sym();
        mode_sel = 1'b0;
        tick(8);
        chk("osc_en0", 24'h000001, 24'(oscillator_enable));
        period("period_p0", 16);
        HOST.send({2'h1, 22'h3FFFFF});
        mode_sel = 1'b1;
        tick(8);
        period("period_max", 4);
        pll_locked = 1'b1;
        tick(8);
        quiet("pump_locked", 64, 1'b0);
        pll_locked = 1'b0;
        HOST.send({2'h0, 22'h000000});
        mode_sel = 1'b0;
        tick(8);
        quiet("pump_tx_low", 300, acquisition_pump_out);
        tx_data = 1'b1;
        tick(8);
        period("period_dev", 16448);
        HOST.send(cw(3'h2, 1'b0, 1'b1));
        tick(8);
        quiet("pump_mm1", 17000, acquisition_pump_out);
        mode_sel = 1'b1;
        tick(8);
        chk("div256", 24'h000000, 24'(divide_512));
        chk("gain2", 24'h000002, 24'(acquisition_gain));
        clk_en = 1'b0;
        tick(100);
        clk_en = 1'b1;
        tick(4);
        chk("gain_wake", 24'h000002, 24'(acquisition_gain));
        period("period_wake", 4);
        complete_run();
    end
endmodule // dfa_top_tb_top
